// [hw/hms_framer.sv]
// Hub management status field framer: forwards the repeated bit stream
// onto the serial management bus and appends seven status bytes.
// Assumes the repeater core drives one bit per link clock cycle, in the
// link clock domain; configuration comes from logic on clk_i.
//
// How it works
// - Report chip address and receiving port number
// - Chip address comes from software register
// - Event flags sent in third status byte
// - Clean flag cleared by early collision
// - Ten-bit first collision bit timer
// - Eight-bit inter-frame gap timer in byte seven
// - Sixteen-bit repeat byte count, low first
// - CRC and alignment errors in byte two
// - Dummy bits byte-align status after misalignment
// - Compression done flag when compression happened
// - Collision flag on any receive/transmit collision
// - Compress stops clock at decode count
// - Status reachable only over management bus
// - Status bytes sent least significant bit first
// - Late compress request leaves packet whole
// - Delimiter filter on by default, disableable
`timescale 1ns/1ps
`include "hms_params.svh"
module hms_framer (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [`HMS_ADDR_W-1:0] chip_addr_i,
    input wire logic [`HMS_DEC_W-1:0] decode_count_i,
    input wire logic [`HMS_GAP_W-1:0] gap_threshold_i,
    input wire logic delimiter_filter_enable_i,
    output logic frame_done_o,
    input wire logic link_clk_i,
    input wire logic rpt_active_i,
    input wire logic rpt_data_i,
    input wire logic sfd_seen_i,
    input wire logic rx_collision_i,
    input wire logic transmit_collision_bit_i,
    input wire logic [`HMS_PORT_W-1:0] port_number_i,
    input wire logic [`HMS_EVT_W-1:0] event_flags_i,
    input wire logic compress_request_in_i,
    output logic mgmt_rx_clock_o,
    output logic mgmt_rx_data_o,
    output logic mgmt_carrier_sense_o,
    output logic mgmt_carrier_sense_oe_n_o
);
    // ---------------- system clock domain ----------------
    logic rst_n;
    logic done_tgl_s;
    logic done_tgl_d;
    hms_pkg::hms_cfg_t cfg;

    hms_sync #(.W(1), .RST_VAL(1'b0)) u_rst_sync (.clk_i(clk_i),
        .rst_n_i(resetn_i), .d_i(1'b1), .q_o(rst_n));

    // the status bytes have no processor-side path at all
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg.chip_addr <= `HMS_ADDR_RST;
            cfg.decode <= `HMS_DEC_RST;
            cfg.gap_thr <= `HMS_THR_RST;
            cfg.delimiter_filter_enable <= `HMS_FILTER_RST;
        end else begin
            cfg.chip_addr <= chip_addr_i;
            cfg.decode <= decode_count_i;
            cfg.gap_thr <= gap_threshold_i;
            cfg.delimiter_filter_enable <= delimiter_filter_enable_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            done_tgl_d <= 1'b0;
        end else begin
            done_tgl_d <= done_tgl_s;
        end
    end
    assign frame_done_o = done_tgl_s ^ done_tgl_d;

    // ---------------- link clock domain ----------------
    logic lrst_n;
    logic comp_req;
    logic done_tgl;
    hms_pkg::hms_cfg_t lcfg;
    hms_pkg::hms_state_t state;
    hms_pkg::hms_status_t stat;
    logic [55:0] shreg;
    logic [5:0] stat_cnt;
    logic [18:0] bit_cnt;
    logic [2:0] align;
    logic sfd_got;
    logic inhibit;
    logic armed;
    logic comp_done;
    logic coll;
    logic tx_coll;
    logic clean;
    logic [`HMS_CT_W-1:0] ct;
    logic [`HMS_GAP_W-1:0] gap_cnt;
    logic [`HMS_GAP_W-1:0] gap_lat;
    logic [`HMS_EVT_W-1:0] evt;
    logic [`HMS_PORT_W-1:0] port;
    logic crc_bad;
    logic any_coll;
    logic fwd;
    logic at_decode;
    logic [15:0] byte_cnt;
    logic [15:0] rpt_count;

    hms_sync #(.W(1), .RST_VAL(1'b0)) u_lrst_sync (.clk_i(link_clk_i),
        .rst_n_i(resetn_i), .d_i(1'b1), .q_o(lrst_n));

    // Configuration is quasi-static, so per-bit synchronising is safe
    // as long as software changes it between frames.
    hms_sync #(.W($bits(hms_pkg::hms_cfg_t)),
               .RST_VAL({`HMS_ADDR_RST, `HMS_DEC_RST, `HMS_THR_RST,
                         `HMS_FILTER_RST})) u_cfg_sync (
        .clk_i(link_clk_i), .rst_n_i(lrst_n), .d_i(cfg), .q_o(lcfg));

    hms_sync #(.W(1), .RST_VAL(1'b0)) u_comp_sync (.clk_i(link_clk_i),
        .rst_n_i(lrst_n), .d_i(compress_request_in_i), .q_o(comp_req));

    hms_sync #(.W(1), .RST_VAL(1'b0)) u_done_sync (.clk_i(clk_i),
        .rst_n_i(rst_n), .d_i(done_tgl), .q_o(done_tgl_s));

    hms_fcs_check u_fcs (.clk_i(link_clk_i), .rst_n_i(lrst_n),
        .clear_i(state == hms_pkg::ST_IDLE || sfd_seen_i),
        .bit_en_i(state != hms_pkg::ST_IDLE && rpt_active_i && sfd_got),
        .bit_i(rpt_data_i), .crc_bad_o(crc_bad));

    assign any_coll = rx_collision_i | transmit_collision_bit_i;
    assign byte_cnt = bit_cnt[18:3];
    // Without a delimiter the count covers the whole packet, 7 bits wide
    assign rpt_count = sfd_got ? byte_cnt :
        ((byte_cnt > `HMS_NSFD_CNT_MAX) ? `HMS_NSFD_CNT_MAX : byte_cnt);
    // Frames dropped by the filter or gap guard carry no status field
    assign fwd = !inhibit && (!lcfg.delimiter_filter_enable || sfd_got);
    assign at_decode = sfd_got && (bit_cnt[2:0] == 3'h0) &&
        (byte_cnt == {8'h00, lcfg.decode});

    always_comb begin
        stat.addr = lcfg.chip_addr;
        stat.port = port;
        stat.comp_done = comp_done;
        stat.tx_coll = tx_coll;
        stat.crc_err = sfd_got & crc_bad;
        stat.align_err = sfd_got & (bit_cnt[2:0] != 3'h0);
        stat.coll = coll;
        stat.clean = clean;
        stat.events = evt;
        stat.ct_high = ct[9:8];
        stat.ct_low = ct[7:0];
        stat.count = rpt_count;
        stat.gap = gap_lat;
    end

    // Gap timer runs whenever nothing is repeated and sticks at the top
    always_ff @(posedge link_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            gap_cnt <= `HMS_GAP_MAX;
        end else if (rpt_active_i) begin
            gap_cnt <= '0;
        end else if (gap_cnt != `HMS_GAP_MAX) begin
            gap_cnt <= gap_cnt + 8'h01;
        end
    end

    // Per-frame collection of flags and counters
    always_ff @(posedge link_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            bit_cnt <= '0;
            sfd_got <= 1'b0;
            coll <= 1'b0;
            tx_coll <= 1'b0;
            clean <= 1'b1;
            ct <= '0;
            gap_lat <= '0;
            evt <= '0;
            port <= '0;
            inhibit <= 1'b0;
        end else if (state == hms_pkg::ST_IDLE) begin
            if (rpt_active_i) begin
                bit_cnt <= 19'h00001;
                sfd_got <= 1'b0;
                coll <= any_coll;
                tx_coll <= transmit_collision_bit_i;
                clean <= !any_coll;
                ct <= '0;
                gap_lat <= gap_cnt;
                evt <= event_flags_i;
                port <= port_number_i;
                // Gap shorter than threshold plus one: carrier only
                inhibit <= ({1'b0, gap_cnt} < ({1'b0, lcfg.gap_thr} + 9'h001));
            end
        end else if (rpt_active_i) begin
            if (sfd_seen_i && !sfd_got) begin
                bit_cnt <= '0;
                sfd_got <= 1'b1;
            end else begin
                bit_cnt <= bit_cnt + 19'h00001;
            end
            coll <= coll | any_coll;
            tx_coll <= tx_coll | transmit_collision_bit_i;
            evt <= evt | event_flags_i;
            if (!coll && ct != `HMS_CT_MAX) begin
                ct <= ct + 10'h001;
            end
            if (any_coll && (!sfd_got ||
                byte_cnt < `HMS_CLN_WINDOW_BYTES)) begin
                clean <= 1'b0;
            end
        end
    end

    // Compression arming: only a request seen before the decode count
    // passes may compress the packet.
    always_ff @(posedge link_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            armed <= 1'b0;
        end else if (state == hms_pkg::ST_IDLE) begin
            armed <= 1'b0;
        end else if (comp_req && !armed && (!sfd_got ||
                     byte_cnt < {8'h00, lcfg.decode} ||
                     (byte_cnt == {8'h00, lcfg.decode} &&
                      bit_cnt[2:0] == 3'h0))) begin
            armed <= 1'b1;
        end
    end

    // Main sequence
    always_ff @(posedge link_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            state <= hms_pkg::ST_IDLE;
            comp_done <= 1'b0;
            align <= '0;
            shreg <= '0;
            stat_cnt <= '0;
            done_tgl <= 1'b0;
        end else begin
            unique case (state)
                hms_pkg::ST_IDLE: begin
                    if (rpt_active_i) begin
                        comp_done <= 1'b0;
                        state <= hms_pkg::ST_DATA;
                    end
                end
                hms_pkg::ST_DATA: begin
                    if (!rpt_active_i) begin
                        shreg <= stat;
                        stat_cnt <= '0;
                        align <= bit_cnt[2:0];
                        if (!fwd) begin
                            state <= hms_pkg::ST_IDLE;
                        end else if (sfd_got && bit_cnt[2:0] != 3'h0) begin
                            state <= hms_pkg::ST_PAD;
                        end else begin
                            state <= hms_pkg::ST_STAT;
                        end
                    end else if (armed && at_decode && fwd) begin
                        comp_done <= 1'b1;
                        state <= hms_pkg::ST_HOLD;
                    end
                end
                hms_pkg::ST_HOLD: begin
                    // Clock held idle until the packet ends
                    if (!rpt_active_i) begin
                        shreg <= stat;
                        stat_cnt <= '0;
                        state <= hms_pkg::ST_STAT;
                    end
                end
                hms_pkg::ST_PAD: begin
                    align <= align + 3'h1;
                    if (align == 3'h7) begin
                        state <= hms_pkg::ST_STAT;
                    end
                end
                hms_pkg::ST_STAT: begin
                    shreg <= {1'b0, shreg[55:1]};
                    stat_cnt <= stat_cnt + 6'h01;
                    if (stat_cnt == `HMS_STAT_BITS - 6'h01) begin
                        done_tgl <= ~done_tgl;
                        state <= hms_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Bus outputs, all registered; clock output is one high cycle per bit
    always_ff @(posedge link_clk_i or negedge lrst_n) begin
        if (!lrst_n) begin
            mgmt_rx_clock_o <= 1'b0;
            mgmt_rx_data_o <= 1'b0;
            mgmt_carrier_sense_o <= 1'b0;
        end else begin
            mgmt_rx_clock_o <= 1'b0;
            mgmt_rx_data_o <= 1'b0;
            mgmt_carrier_sense_o <= 1'b0;
            unique case (state)
                hms_pkg::ST_IDLE: begin
                    if (rpt_active_i && !lcfg.delimiter_filter_enable &&
                        gap_cnt > lcfg.gap_thr) begin
                        mgmt_carrier_sense_o <= 1'b1;
                        mgmt_rx_clock_o <= 1'b1;
                        mgmt_rx_data_o <= rpt_data_i;
                    end
                end
                hms_pkg::ST_DATA: begin
                    mgmt_carrier_sense_o <= fwd || inhibit;
                    if (rpt_active_i && fwd && !(armed && at_decode)) begin
                        mgmt_rx_clock_o <= 1'b1;
                        mgmt_rx_data_o <= rpt_data_i;
                    end else if (!rpt_active_i) begin
                        mgmt_carrier_sense_o <= fwd;
                    end
                end
                hms_pkg::ST_HOLD: begin
                    mgmt_carrier_sense_o <= 1'b1;
                end
                hms_pkg::ST_PAD: begin
                    mgmt_carrier_sense_o <= 1'b1;
                    mgmt_rx_clock_o <= 1'b1;
                end
                hms_pkg::ST_STAT: begin
                    mgmt_carrier_sense_o <= 1'b1;
                    mgmt_rx_clock_o <= 1'b1;
                    mgmt_rx_data_o <= shreg[0];
                end
            endcase
        end
    end

    // Open drain: pulled low only while carrier is asserted
    assign mgmt_carrier_sense_oe_n_o = !mgmt_carrier_sense_o;
endmodule // hms_framer

// [hw/hms_params.svh]
// Constants for the hub management status field framer.
// Included by the package users; holds definitions only.
`ifndef HMS_PARAMS_SVH
`define HMS_PARAMS_SVH
`define HMS_ADDR_W 6
`define HMS_PORT_W 4
`define HMS_EVT_W 6
`define HMS_CT_W 10
`define HMS_CT_MAX 10'h3ff
`define HMS_CNT_W 16
`define HMS_GAP_W 8
`define HMS_GAP_MAX 8'hff
`define HMS_DEC_W 8
`define HMS_STAT_BYTES 7
`define HMS_STAT_BITS 6'h38
`define HMS_CLN_WINDOW_BYTES 16'h000d
`define HMS_NSFD_CNT_MAX 16'h007f
`define HMS_CRC_INIT 32'hffffffff
`define HMS_CRC_POLY 32'h04c11db7
`define HMS_CRC_RESIDUE 32'hc704dd7b
`define HMS_FILTER_RST 1'b1
`define HMS_ADDR_RST 6'h00
`define HMS_DEC_RST 8'h00
`define HMS_THR_RST 8'h00
`endif

// [hw/hms_pkg.sv]
// Types shared by the status field framer and its helpers.
// Widths come from hms_params.svh.
`include "hms_params.svh"
package hms_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_DATA, ST_HOLD, ST_PAD, ST_STAT
    } hms_state_t;

    // Software configuration, quasi-static while frames pass
    typedef struct packed {
        logic [`HMS_ADDR_W-1:0] chip_addr;
        logic [`HMS_DEC_W-1:0] decode;
        logic [`HMS_GAP_W-1:0] gap_thr;
        logic delimiter_filter_enable;
    } hms_cfg_t;

    // The seven status bytes, last byte in the top bits
    typedef struct packed {
        logic [7:0] gap;
        logic [15:0] count;
        logic [7:0] ct_low;
        logic [5:0] events;
        logic [1:0] ct_high;
        logic crc_err;
        logic align_err;
        logic coll;
        logic clean;
        logic [3:0] port;
        logic [5:0] addr;
        logic comp_done;
        logic tx_coll;
    } hms_status_t;
endpackage

// [hw/hms_sync.sv]
// Two flip-flop synchroniser, any width.
// Assumes the source holds each value for several destination cycles.
`timescale 1ns/1ps
module hms_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // hms_sync

// [hw/hms_fcs_check.sv]
// Serial CRC-32 checker over the post-delimiter bit stream.
// Bits arrive least significant first, one per enabled cycle.
`timescale 1ns/1ps
`include "hms_params.svh"
module hms_fcs_check (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clear_i,
    input wire logic bit_en_i,
    input wire logic bit_i,
    output logic crc_bad_o
);
    logic [31:0] crc;
    logic fb;

    assign fb = crc[31] ^ bit_i;
    // A good frame including its FCS leaves the fixed residue
    assign crc_bad_o = (crc != `HMS_CRC_RESIDUE);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crc <= `HMS_CRC_INIT;
        end else if (clear_i) begin
            crc <= `HMS_CRC_INIT;
        end else if (bit_en_i) begin
            crc <= {crc[30:0], 1'b0} ^ (fb ? `HMS_CRC_POLY : 32'h00000000);
        end
    end
endmodule // hms_fcs_check

// [tb/hms_framer_properties.sv]
// Port checker for the status field framer, bound to every instance.
// Assumes configuration stays steady while a frame passes.
`timescale 1ns/1ps
module hms_framer_properties (
    input wire logic link_clk_i,
    input wire logic resetn_i,
    input wire logic delimiter_filter_enable_i,
    input wire logic rpt_active_i,
    input wire logic rpt_data_i,
    input wire logic mgmt_rx_clock_o,
    input wire logic mgmt_rx_data_o,
    input wire logic mgmt_carrier_sense_o,
    input wire logic mgmt_carrier_sense_oe_n_o
);
    logic [5:0] run;

    default clocking @(posedge link_clk_i); endclocking
    default disable iff (!resetn_i);

    // Unbroken run of clocked bits; saturates so long runs stay legal
    always_ff @(posedge link_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            run <= 6'h00;
        end else if (!mgmt_rx_clock_o) begin
            run <= 6'h00;
        end else if (run != 6'h3f) begin
            run <= run + 6'h01;
        end
    end

    clock_needs_carrier_a: assert property (
        mgmt_rx_clock_o |-> mgmt_carrier_sense_o)
        else $error("bit clock without carrier");
    carrier_drive_a: assert property (
        mgmt_carrier_sense_oe_n_o != mgmt_carrier_sense_o)
        else $error("carrier enable disagrees with carrier");
    data_follows_a: assert property (
        mgmt_rx_clock_o && $past(rpt_active_i)
        |-> mgmt_rx_data_o == $past(rpt_data_i))
        else $error("forwarded bit differs from repeated bit");
    filter_blocks_a: assert property (
        $rose(rpt_active_i) && delimiter_filter_enable_i |=> !mgmt_rx_clock_o)
        else $error("preamble forwarded with filter on");
    filter_off_passes_a: assert property (
        $rose(rpt_active_i) && !delimiter_filter_enable_i |=> mgmt_rx_clock_o)
        else $error("first bit not forwarded with filter off");
    carrier_held_a: assert property (
        $fell(rpt_active_i) && mgmt_carrier_sense_o
        |=> mgmt_carrier_sense_o [*8])
        else $error("carrier dropped before status");
    status_closes_a: assert property (
        $fell(rpt_active_i) && mgmt_carrier_sense_o
        |-> ##[57:70] !mgmt_carrier_sense_o)
        else $error("status field length wrong");
    status_whole_a: assert property (
        $fell(mgmt_carrier_sense_o) && $past(mgmt_rx_clock_o)
        |-> run >= 6'h38)
        else $error("status bits not contiguous");
endmodule // hms_framer_properties

bind hms_framer hms_framer_properties props (.link_clk_i, .resetn_i,
    .delimiter_filter_enable_i, .rpt_active_i, .rpt_data_i,
    .mgmt_rx_clock_o, .mgmt_rx_data_o, .mgmt_carrier_sense_o,
    .mgmt_carrier_sense_oe_n_o);

// [tb/hms_mgmt_model.sv]
// Far-side model: the controller capturing the management stream and
// the compress logic raising its request after a set bit count.
// Assumes the bench clears it between frames.
`timescale 1ns/1ps
module hms_mgmt_model (
    input wire logic link_clk_i,
    input wire logic clear_i,
    input wire logic [8:0] comp_bit_i,
    input wire logic mgmt_rx_clock_i,
    input wire logic mgmt_rx_data_i,
    input wire logic mgmt_carrier_sense_i,
    output logic compress_request_in_o
);
    logic rx_bits [0:1023];
    int nbits = 0;
    int crs_cycles = 0;

    initial compress_request_in_o = 1'b0;

    always @(posedge link_clk_i) begin
        if (clear_i) begin
            nbits <= 0;
            crs_cycles <= 0;
            compress_request_in_o <= 1'b0;
        end else begin
            if (mgmt_carrier_sense_i) begin
                crs_cycles <= crs_cycles + 1;
            end
            if (mgmt_rx_clock_i) begin
                rx_bits[nbits] <= mgmt_rx_data_i;
                nbits <= nbits + 1;
            end
            // Zero means never; a late count exercises a refused request
            if (comp_bit_i != 9'h000 && nbits >= comp_bit_i) begin
                compress_request_in_o <= 1'b1;
            end
        end
    end
endmodule // hms_mgmt_model

// [tb/tb_hub_mgmt_status_field.sv]
// Self-checking bench for the status field framer: drives frames in the
// link domain, checks the stream captured by the bus model.
`timescale 1ns/1ps
module tb_hub_mgmt_status_field;
    logic clk_i = 1'b0, link_clk = 1'b0, resetn = 1'b0;
    logic filt_en = 1'b1, rpt_active = 1'b0, rpt_data = 1'b0;
    logic sfd_seen = 1'b0, rx_col = 1'b0, tx_col = 1'b0, mdl_clear = 1'b0;
    logic [5:0] chip_addr = 6'h00, evt = 6'h00;
    logic [7:0] decode = 8'h00;
    logic [3:0] port_num = 4'h0;
    logic [8:0] comp_bit = 9'h000;
    logic comp_req, done, mgmt_rx_clock, mgmt_rx_data, crs_o, crs_oe_n, crs;
    logic fb [0:1023];
    int mismatches = 0, checks = 0, cyc = 0, done_cnt = 0, seq = 0;
    int idle = 330, last_idle = 330;

    always #2 clk_i = ~clk_i;
    initial begin
        #7;
        forever #32 link_clk = ~link_clk;
    end
    // Open-drain carrier reads inactive when released
    assign crs = !crs_oe_n && crs_o;

    hms_framer dut (.clk_i(clk_i), .resetn_i(resetn),
        .chip_addr_i(chip_addr), .decode_count_i(decode),
        .gap_threshold_i(8'h00), .delimiter_filter_enable_i(filt_en),
        .frame_done_o(done), .link_clk_i(link_clk),
        .rpt_active_i(rpt_active), .rpt_data_i(rpt_data),
        .sfd_seen_i(sfd_seen), .rx_collision_i(rx_col),
        .transmit_collision_bit_i(tx_col), .port_number_i(port_num),
        .event_flags_i(evt), .compress_request_in_i(comp_req),
        .mgmt_rx_clock_o(mgmt_rx_clock), .mgmt_rx_data_o(mgmt_rx_data),
        .mgmt_carrier_sense_o(crs_o), .mgmt_carrier_sense_oe_n_o(crs_oe_n));
    hms_mgmt_model mdl (.link_clk_i(link_clk), .clear_i(mdl_clear),
        .comp_bit_i(comp_bit), .mgmt_rx_clock_i(mgmt_rx_clock),
        .mgmt_rx_data_i(mgmt_rx_data), .mgmt_carrier_sense_i(crs),
        .compress_request_in_o(comp_req));

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (done === 1'b1) done_cnt <= done_cnt + 1;
        if (cyc == 95000) begin
            mismatches++;
            $display("[ERR] %0t timeout", $time);
            summarize();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
            input string what);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Reflected CRC-32, no final inversion
    function automatic logic [31:0] crc(input int from, input int n);
        logic [31:0] c;
        c = 32'hffffffff;
        for (int i = from; i < from + n; i++)
            c = (c >> 1) ^ ((c[0] ^ fb[i]) ? 32'hedb88320 : 32'h0);
        return c;
    endfunction

    task automatic run(input string name, input int npre, input int nby,
            input int extra, input int col, input bit tx, input int cb,
            input int dec, input bit filt);
        int fl, post, nf, off, npad, d0;
        bit sfd, snd, comp;
        logic [31:0] c;
        logic [55:0] got;
        logic [5:0] a, e;
        logic [3:0] p;
        hms_pkg::hms_status_t es, mk;
        sfd = npre > 0;
        fl = npre + nby * 8 + extra;
        post = fl - npre;
        for (int i = 0; i < fl; i++)
            fb[i] = i < npre ? (i % 2 == 0 || i == npre - 1) : i[1] ^ i[4];
        if (sfd) begin
            c = crc(npre, nby * 8 - 32);
            for (int k = 0; k < 32; k++)
                fb[npre + nby * 8 - 32 + k] = ~c[k];
        end
        a = 6'h3f - 6'(seq * 7);
        e = 6'(1 << (seq % 6));
        p = 4'(seq % 13);
        seq++;
        comp = cb > 0 && cb < dec * 8 && dec * 8 < post;
        snd = sfd || !filt;
        off = filt ? npre : 0;
        nf = !snd ? 0 : comp ? dec * 8 : fl - off;
        npad = (sfd && post % 8 != 0) ? 8 - post % 8 : 0;
        es = '0;
        es.addr = a;
        es.comp_done = comp;
        es.port = p;
        es.events = e;
        es.coll = col >= 0;
        es.clean = col < 0 || (sfd && col >= npre + 104);
        es.align_err = post % 8 != 0;
        es.crc_err = crc(npre, post) != 32'hdebb20e3;
        {es.ct_high, es.ct_low} = col[9:0];
        es.count = 16'(sfd ? post / 8 : fl / 8);
        // Gap spans the previous idle wait plus seven set-up edges
        es.gap = 8'(last_idle + 7 > 255 ? 255 : last_idle + 7);
        mk = '1;
        mk.tx_coll = 1'b0;
        if (col < 0) {mk.ct_high, mk.ct_low} = 10'h000;
        if (col >= 0 || !sfd) mk.crc_err = 1'b0;
        if (!sfd) mk.align_err = 1'b0;
        @(posedge clk_i);
        chip_addr <= a;
        decode <= 8'(dec);
        filt_en <= filt;
        @(posedge link_clk);
        mdl_clear <= 1'b1;
        comp_bit <= 9'(cb);
        @(posedge link_clk);
        mdl_clear <= 1'b0;
        repeat (4) @(posedge link_clk);
        d0 = done_cnt;
        for (int i = 0; i < fl; i++) begin
            @(posedge link_clk);
            rpt_active <= 1'b1;
            rpt_data <= fb[i];
            sfd_seen <= sfd && i == npre - 1;
            rx_col <= !tx && col >= 0 && i >= col;
            tx_col <= tx && col >= 0 && i >= col;
            port_num <= p;
            evt <= e;
        end
        @(posedge link_clk);
        rpt_active <= 1'b0;
        sfd_seen <= 1'b0;
        rx_col <= 1'b0;
        tx_col <= 1'b0;
        evt <= 6'h00;
        // Idle sets the gap that the next frame reports
        repeat (idle) @(posedge link_clk);
        last_idle = idle;
        chk(mdl.nbits, nf + npad + (snd ? 56 : 0), "bits");
        chk(mdl.crs_cycles > 0, snd, "carrier");
        chk(done_cnt - d0, snd, "frame done");
        for (int i = 0; i < nf; i++)
            chk(mdl.rx_bits[i], fb[off + i], "data bit");
        for (int i = nf; i < nf + npad; i++)
            chk(mdl.rx_bits[i], 1'b0, "pad bit");
        for (int i = 0; i < 56; i++)
            got[i] = mdl.rx_bits[nf + npad + i];
        if (snd)
            chk(got & mk, es & mk, "status");
        $display("test %s done", name);
    endtask

    initial begin
        repeat (3) @(posedge link_clk);
        resetn <= 1'b1;
        repeat (8) @(posedge link_clk);
        run("plain", 8, 12, 0, -1, 0, 0, 0, 1);
        run("misaligned", 8, 12, 3, -1, 0, 0, 0, 1);
        run("early_coll", 8, 12, 0, 40, 0, 0, 0, 1);
        // Short gaps from here on, still past the status field and checks
        idle = 100;
        run("window_edge", 8, 16, 0, 111, 0, 0, 0, 1);
        run("tx_coll_late", 8, 16, 0, 112, 1, 0, 0, 1);
        run("compress", 8, 12, 0, -1, 0, 8, 4, 1);
        run("late_compress", 8, 12, 0, -1, 0, 48, 2, 1);
        run("no_delim_on", 0, 8, 0, -1, 0, 0, 0, 1);
        run("no_delim_off", 0, 16, 0, -1, 0, 0, 0, 0);
        summarize();
    end
endmodule // tb_hub_mgmt_status_field
